/* rtl/pma_pkg.sv */
// Constants for the power-profile and alarm-summary register slice.
// Assumes an 8-bit register port with a 12-bit address on one clock.
// Notes on behaviour
// RL1 - Second profile: 0x06 low, 0x0F high default
// RL2 - Third profile: 0x00 low, 0x04 high default
// RL3 - Fourth profile: 0x14 low, 0x1B high default
// RL4 - Host writes all profile registers together
// RL5 - Low-power codes only at or below 1 GSPS
// RL6 - Host calibrates after any mode change
// RL7 - Host clears calibration and link enables first
// RL8 - Summary bit 0 is OR of unmasked alarms
// RL9 - Masked alarm excluded from summary bit
// RL10 - Summary drives status pin when selected
// RL11 - Alarm flags sticky, cleared by writing one
// RL12 - Alarm flags reset set, value 0x3F
// RL13 - Mask bits block alarms, reset to ones
// RL14 - Summary recomputed each cycle, no extra latching
package pma_pkg;
  localparam int          ADDR_W            = 12;
  localparam int          DATA_W            = 8;
  localparam int          ALM_W             = 6;
  localparam logic [11:0] OFS_PROFILE_2     = 12'h029A;
  localparam logic [11:0] OFS_PROFILE_3     = 12'h029B;
  localparam logic [11:0] OFS_PROFILE_4     = 12'h029C;
  localparam logic [11:0] OFS_ALARM_SUM     = 12'h02C0;
  localparam logic [11:0] OFS_ALARM_FLAGS   = 12'h02C1;
  localparam logic [11:0] OFS_ALARM_MASK    = 12'h02C2;
  localparam logic [7:0]  PROF2_LOW         = 8'h06;
  localparam logic [7:0]  PROF2_HIGH        = 8'h0F;
  localparam logic [7:0]  PROF3_LOW         = 8'h00;
  localparam logic [7:0]  PROF3_HIGH        = 8'h04;
  localparam logic [7:0]  PROF4_LOW         = 8'h14;
  localparam logic [7:0]  PROF4_HIGH        = 8'h1B;
  localparam logic [5:0]  ALARM_FLAGS_RST   = 6'h3F;
  localparam logic [5:0]  ALARM_MASK_RST    = 6'h3F;
  localparam int          ALARM_SUM_BIT     = 0;
endpackage

/* rtl/pma_alarm_flags.sv */
// Sticky alarm flags with write-one-to-clear.
// Assumes event pulses synchronous to mclk_i.
`timescale 1ns/1ps
module pma_alarm_flags
  import pma_pkg::*;
#(
  parameter int WIDTH = ALM_W
) (
  input  wire logic             mclk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] event_i,
  input  wire logic [WIDTH-1:0] clear_i,
  output logic      [WIDTH-1:0] flags_o
);
  // Refuse widths the reset constant cannot cover
  if (WIDTH < 1 || WIDTH > ALM_W) begin : g_bad_width
    $error("pma_alarm_flags: WIDTH out of range");
  end

  // Per-bit flag, set wins over clear
  for (genvar g = 0; g < WIDTH; g++) begin : g_flag
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        flags_o[g] <= ALARM_FLAGS_RST[g]; // RL12
      end else if (event_i[g]) begin
        flags_o[g] <= 1'b1; // RL11
      end else if (clear_i[g]) begin
        flags_o[g] <= 1'b0; // RL11
      end
    end
  end

  // A set flag stays set unless written with one
  sticky_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL11
    ((($past(flags_o) & ~$past(clear_i)) & ~flags_o) == '0))
    else $error("Sticky flag dropped without a clear");
  // An event sets its flag, even against a clear
  event_set_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL11
    (event_i != '0) |=> ((flags_o & $past(event_i)) == $past(event_i)))
    else $error("Alarm event did not set its flag");
endmodule

/* rtl/pma_regs.sv */
// Power-profile and alarm-summary registers behind the configuration port.
// Assumes a one-cycle write strobe and a registered read answer.
`timescale 1ns/1ps
module pma_regs
  import pma_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  input  wire logic              wr_en_i,
  input  wire logic              rd_en_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [ALM_W-1:0]  alarm_event_i,
  input  wire logic              cal_status_i,
  input  wire logic              status_sel_alarm_i,
  output logic      [DATA_W-1:0] rdata_o,
  output logic                   rvalid_o,
  output logic      [DATA_W-1:0] profile_code_second_o,
  output logic      [DATA_W-1:0] profile_code_third_o,
  output logic      [DATA_W-1:0] profile_code_fourth_o,
  output logic                   status_output_pin_o
);
  logic [ALM_W-1:0]  alarm_sticky_flags;
  logic [ALM_W-1:0]  alarm_mask_bits;
  logic [DATA_W-1:0] alarm_summary;

  // Refuse field widths the zero padding cannot serve
  if (DATA_W != 8 || ALM_W < 1 || ALM_W >= DATA_W) begin : g_bad_cfg
    $error("pma_regs: alarm field does not fit the data word");
  end

  // Address decode
  wire hit_p2   = addr_i == OFS_PROFILE_2;
  wire hit_p3   = addr_i == OFS_PROFILE_3;
  wire hit_p4   = addr_i == OFS_PROFILE_4;
  wire hit_sum  = addr_i == OFS_ALARM_SUM;
  wire hit_flag = addr_i == OFS_ALARM_FLAGS;
  wire hit_mask = addr_i == OFS_ALARM_MASK;
  wire hit_any  = hit_p2 | hit_p3 | hit_p4 | hit_sum | hit_flag | hit_mask;

  // Write-one-to-clear pulses for the sticky flags
  wire [ALM_W-1:0] flag_clear = (wr_en_i && hit_flag) ? wdata_i[ALM_W-1:0] : '0; // RL11

  // Summary is a plain combinational OR of unmasked flags
  wire summary_bit = |(alarm_sticky_flags & ~alarm_mask_bits); // RL8 RL9 RL13 RL14
  assign alarm_summary = {{(DATA_W-1){1'b0}}, summary_bit}; // RL8

  // Read mux, unmapped addresses read zero
  wire [DATA_W-1:0] next_rdata =
    hit_p2   ? profile_code_second_o :
    hit_p3   ? profile_code_third_o :
    hit_p4   ? profile_code_fourth_o :
    hit_sum  ? alarm_summary :
    hit_flag ? {{(DATA_W-ALM_W){1'b0}}, alarm_sticky_flags} :
    hit_mask ? {{(DATA_W-ALM_W){1'b0}}, alarm_mask_bits} : 8'h00;

  // Status pin source select
  wire next_status_pin = status_sel_alarm_i ? summary_bit : cal_status_i; // RL10

  pma_alarm_flags #(
    .WIDTH(ALM_W)
  ) u_flags (
    .mclk_i (mclk_i),
    .rst_n_i(rst_n_i),
    .event_i(alarm_event_i),
    .clear_i(flag_clear),
    .flags_o(alarm_sticky_flags)
  );

  // Profile and mask registers; any written profile code is stored, reserved codes included
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      profile_code_second_o <= PROF2_HIGH; // RL1
      profile_code_third_o  <= PROF3_HIGH; // RL2
      profile_code_fourth_o <= PROF4_HIGH; // RL3
      alarm_mask_bits       <= ALARM_MASK_RST; // RL13
    end else if (wr_en_i) begin
      if (hit_p2) profile_code_second_o <= wdata_i; // RL1
      if (hit_p3) profile_code_third_o <= wdata_i; // RL2
      if (hit_p4) profile_code_fourth_o <= wdata_i; // RL3
      if (hit_mask) alarm_mask_bits <= wdata_i[ALM_W-1:0]; // RL13
    end
  end

  // Registered read answer and status pin
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o             <= 8'h00;
      rvalid_o            <= 1'b0;
      status_output_pin_o <= 1'b0;
    end else begin
      rvalid_o            <= rd_en_i;
      status_output_pin_o <= next_status_pin; // RL10
      if (rd_en_i) rdata_o <= next_rdata;
    end
  end

  // Request sequences shared by the checks below
  sequence pma_rd_sum_seq;
    rd_en_i && hit_sum;
  endsequence
  sequence pma_rd_flag_seq;
    rd_en_i && hit_flag;
  endsequence
  sequence pma_rd_none_seq;
    rd_en_i && !hit_any;
  endsequence
  sequence pma_clear_last_seq;
    wr_en_i && hit_flag && (alarm_event_i == '0) &&
      ((alarm_sticky_flags & ~alarm_mask_bits & ~wdata_i[ALM_W-1:0]) == '0);
  endsequence
  sequence pma_mask_all_seq;
    wr_en_i && hit_mask && (wdata_i[ALM_W-1:0] == ALARM_MASK_RST);
  endsequence

  // Summary read answers with the live OR of unmasked flags
  summary_rd_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL8
    pma_rd_sum_seq |=>
      (rdata_o == {{(DATA_W-1){1'b0}}, $past(|(alarm_sticky_flags & ~alarm_mask_bits))}))
    else $error("Summary read mismatch");

  // Upper summary bits always read zero
  sum_rsvd_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL8
    pma_rd_sum_seq |=> (rdata_o[DATA_W-1:1] == '0))
    else $error("Reserved summary bits not zero");

  // All masks set keep the selected pin low
  mask_block_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL9
    (status_sel_alarm_i && (alarm_mask_bits == ALARM_MASK_RST)) |=> !status_output_pin_o)
    else $error("Masked alarms reached the summary");

  // Writing every mask silences the pin two cycles on
  mask_wr_quiet_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL13
    pma_mask_all_seq ##1 status_sel_alarm_i |=> !status_output_pin_o)
    else $error("Mask write did not silence the pin");

  // Pin follows the summary when selected
  pin_alarm_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL10
    status_sel_alarm_i |=> (status_output_pin_o == $past(summary_bit)))
    else $error("Status pin does not follow summary");

  // Pin follows calibration status otherwise
  pin_cal_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL10
    !status_sel_alarm_i |=> (status_output_pin_o == $past(cal_status_i)))
    else $error("Status pin does not follow calibration");

  // Second profile takes a write
  prof2_wr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL1
    (wr_en_i && hit_p2) |=> (profile_code_second_o == $past(wdata_i)))
    else $error("Second profile write lost");

  // Second profile keeps its code between writes
  prof2_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL1
    !(wr_en_i && hit_p2) |=> $stable(profile_code_second_o))
    else $error("Second profile changed without write");

  // Third profile takes a write
  prof3_wr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL2
    (wr_en_i && hit_p3) |=> (profile_code_third_o == $past(wdata_i)))
    else $error("Third profile write lost");

  // Third profile keeps its code between writes
  prof3_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL2
    !(wr_en_i && hit_p3) |=> $stable(profile_code_third_o))
    else $error("Third profile changed without write");

  // Fourth profile takes a write
  prof4_wr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL3
    (wr_en_i && hit_p4) |=> (profile_code_fourth_o == $past(wdata_i)))
    else $error("Fourth profile write lost");

  // Fourth profile keeps its code between writes
  prof4_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL3
    !(wr_en_i && hit_p4) |=> $stable(profile_code_fourth_o))
    else $error("Fourth profile changed without write");

  // Write-one clears the flag when no event races it
  w1c_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL11
    (wr_en_i && hit_flag && (alarm_event_i == '0)) |=>
      ((alarm_sticky_flags & $past(wdata_i[ALM_W-1:0])) == '0))
    else $error("Write-one did not clear flag");

  // Writing zeros never drops a flag
  w1c_zero_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL11
    (wr_en_i && hit_flag && (wdata_i == '0)) |=> ((~alarm_sticky_flags & $past(alarm_sticky_flags)) == '0))
    else $error("Zero write dropped a flag");

  // Flag read returns the sticky bits, upper bits zero
  flag_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL11
    pma_rd_flag_seq |=> (rdata_o == {{(DATA_W-ALM_W){1'b0}}, $past(alarm_sticky_flags)}))
    else $error("Flag read mismatch");

  // Mask register takes a write
  mask_wr_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL13
    (wr_en_i && hit_mask) |=> (alarm_mask_bits == $past(wdata_i[ALM_W-1:0])))
    else $error("Mask write lost");

  // Mask register keeps its bits between writes
  mask_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL13
    !(wr_en_i && hit_mask) |=> $stable(alarm_mask_bits))
    else $error("Mask changed without write");

  // Any unmasked flag raises the selected pin
  summary_live_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL14
    (status_sel_alarm_i && ((alarm_sticky_flags & ~alarm_mask_bits) != '0)) |=> status_output_pin_o)
    else $error("Summary not asserted for unmasked flag");

  // Clearing the last unmasked flag drops the pin, no latching
  summary_drop_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RL14
    pma_clear_last_seq ##1 status_sel_alarm_i |=> !status_output_pin_o)
    else $error("Summary held after last clear");

  // Read valid is a one-cycle echo of the strobe
  rvalid_pulse_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    rvalid_o == $past(rd_en_i))
    else $error("Read valid out of step");

  // Read data holds until the next read
  rdata_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    !rd_en_i |=> $stable(rdata_o))
    else $error("Read data changed without read");

  // Unmapped reads answer zero
  unmapped_rd_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    pma_rd_none_seq |=> (rdata_o == '0))
    else $error("Unmapped read not zero");
endmodule

/* sim/pma_host.sv */
// Host model on the configuration port of the register slice.
// Assumes the block's mclk_i; drives just after each rising edge.
`timescale 1ns/1ps
module pma_host
  import pma_pkg::*;
#(
  parameter int RATE_MSPS = 800
) (
  input  wire logic              mclk_i,
  output logic                   wr_en_o,
  output logic                   rd_en_o,
  output logic      [ADDR_W-1:0] addr_o,
  output logic      [DATA_W-1:0] wdata_o,
  input  wire logic [DATA_W-1:0] rdata_i
);
  logic cal_engine_en      = 1'b1;
  logic serial_link_enable = 1'b1;
  int   cal_runs           = 0;
  // Idle bus from time zero
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o  = '0;
    wdata_o = '0;
  end
  // One write, taken at the edge after the strobe rises
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    #1 wr_en_o = 1'b1;
    addr_o  = a;
    wdata_o = d;
    @(posedge mclk_i);
    #1 wr_en_o = 1'b0;
  endtask
  // One read, data taken a cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    #1 rd_en_o = 1'b1;
    addr_o  = a;
    @(posedge mclk_i);
    #1 rd_en_o = 1'b0;
    d = rdata_i;
  endtask
  // Whole-set mode change, then calibration
  task automatic set_mode(input logic low);
    if (low && RATE_MSPS > 1000) return;
    cal_engine_en      = 1'b0;
    serial_link_enable = 1'b0;
    wr(OFS_PROFILE_2, low ? PROF2_LOW : PROF2_HIGH);
    wr(OFS_PROFILE_3, low ? PROF3_LOW : PROF3_HIGH);
    wr(OFS_PROFILE_4, low ? PROF4_LOW : PROF4_HIGH);
    cal_runs++;
    serial_link_enable = 1'b1;
    cal_engine_en      = 1'b1;
  endtask
endmodule

/* sim/power_mode_alarm_regs_tb.sv */
// Self-checking bench for the power-profile and alarm-summary slice.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module power_mode_alarm_regs_tb;
  import pma_pkg::*;
  logic             mclk_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic [ALM_W-1:0] evt = '0;
  logic             cal = 1'b0;
  logic             sel = 1'b0;
  logic             we, re, rv, pin;
  logic [11:0]      ad;
  logic [7:0]       wd, rdat, p2, p3, p4;
  int               failures = 0;
  int               checks_done = 0;
  int               cycles = 0;
  pma_host i_pma_host (.mclk_i(mclk_i), .wr_en_o(we), .rd_en_o(re), .addr_o(ad), .wdata_o(wd), .rdata_i(rdat));
  pma_regs i_pma_regs (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .wr_en_i(we), .rd_en_i(re), .addr_i(ad),
    .wdata_i(wd), .alarm_event_i(evt), .cal_status_i(cal), .status_sel_alarm_i(sel), .rdata_o(rdat),
    .rvalid_o(rv), .profile_code_second_o(p2), .profile_code_third_o(p3), .profile_code_fourth_o(p4),
    .status_output_pin_o(pin));
  // 20 MHz clock
  initial begin
    forever #25 mclk_i = ~mclk_i;
  end
  // Hang guard
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_pma_host.rd(a, d);
    chk({7'h00, rv}, 8'h01);
    chk(d, exp);
  endtask
  task automatic t_reset;
    chk(p2, PROF2_HIGH);
    chk(p3, PROF3_HIGH);
    chk(p4, PROF4_HIGH);
    rdc(OFS_ALARM_FLAGS, 8'h3F);
    rdc(OFS_ALARM_MASK, 8'h3F);
    rdc(OFS_ALARM_SUM, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_profile;
    i_pma_host.set_mode(1'b1);
    chk(p2, PROF2_LOW);
    chk(p4, PROF4_LOW);
    rdc(OFS_PROFILE_3, PROF3_LOW);
    i_pma_host.set_mode(1'b0);
    rdc(OFS_PROFILE_2, PROF2_HIGH);
    chk(p3, PROF3_HIGH);
    chk(p4, PROF4_HIGH);
    $display("profile test done");
  endtask
  task automatic t_alarm;
    sel = 1'b1;
    cal = 1'b1;
    i_pma_host.wr(OFS_ALARM_MASK, 8'h3E);
    rdc(OFS_ALARM_SUM, 8'h01);
    chk({7'h00, pin}, 8'h01);
    i_pma_host.wr(OFS_ALARM_FLAGS, 8'h00);
    rdc(OFS_ALARM_FLAGS, 8'h3F);
    i_pma_host.wr(OFS_ALARM_FLAGS, 8'h01);
    rdc(OFS_ALARM_FLAGS, 8'h3E);
    chk({7'h00, pin}, 8'h00);
    i_pma_host.wr(OFS_ALARM_SUM, 8'hFF);
    rdc(OFS_ALARM_SUM, 8'h00);
    evt = 6'h01;
    @(posedge mclk_i);
    #1 evt = 6'h00;
    rdc(OFS_ALARM_SUM, 8'h01);
    fork
      i_pma_host.wr(OFS_ALARM_FLAGS, 8'h03);
      begin
        @(posedge mclk_i);
        #1 evt = 6'h01;
        @(posedge mclk_i);
        #1 evt = 6'h00;
      end
    join
    rdc(OFS_ALARM_FLAGS, 8'h3D);
    i_pma_host.wr(OFS_ALARM_MASK, 8'h3F);
    rdc(OFS_ALARM_SUM, 8'h00);
    chk({7'h00, pin}, 8'h00);
    sel = 1'b0;
    rdc(OFS_PROFILE_3, PROF3_HIGH);
    chk({7'h00, pin}, 8'h01);
    cal = 1'b0;
    rdc(12'h0123, 8'h00);
    chk({7'h00, pin}, 8'h00);
    $display("alarm test done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (4) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    t_reset();
    t_profile();
    t_alarm();
    wrap_up();
  end
endmodule
